/* logic/irq_map_pkg.sv */
/*
 Constants for the interrupt request map, requests 10 to 23: vector
 table addresses, level register layout, register offsets.
 Assumes a 32-bit AXI4-Lite slave with byte addresses.
*/
package irq_map_pkg;
	localparam int unsigned first_irq = 10;
	localparam int unsigned num_irq = 14;
	localparam int unsigned num_src = 18;
	// Vector of request n: upper at vec_base - 2*n, lower one above
	localparam logic [15:0] vec_base = 16'hfffa;
	localparam logic [15:0] vec_upper [num_irq] = '{
		16'hffe6, 16'hffe4, 16'hffe2, 16'hffe0, 16'hffde, 16'hffdc,
		16'hffda, 16'hffd8, 16'hffd6, 16'hffd4, 16'hffd2, 16'hffd0,
		16'hffce, 16'hffcc};
	// Level registers: four two-bit fields, request 8 at bits 1:0 of reg two
	localparam int unsigned lvl_field_w = 2;
	localparam int unsigned lvl_per_reg = 4;
	localparam logic [7:0] lvl_reset = 8'hff;
	// Register byte offsets
	localparam logic [7:0] off_lvl_two = 8'h00;
	localparam logic [7:0] off_lvl_three = 8'h04;
	localparam logic [7:0] off_lvl_four = 8'h08;
	localparam logic [7:0] off_lvl_five = 8'h0c;
	localparam logic [7:0] off_status = 8'h10;
	localparam logic [7:0] off_mask = 8'h14;
	localparam logic [7:0] off_vector = 8'h18;
	localparam logic [7:0] off_pending = 8'h1c;
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
	// Sources, in port order
	localparam int unsigned src_ppu1_hi = 0;
	localparam int unsigned src_ppu2_hi = 1;
	localparam int unsigned src_ppu0_hi = 2;
	localparam int unsigned src_ppu0_lo = 3;
	localparam int unsigned src_ctm1_hi = 4;
	localparam int unsigned src_ppu2_lo = 5;
	localparam int unsigned src_reload1 = 6;
	localparam int unsigned src_motor_wt = 7;
	localparam int unsigned src_i2c0 = 8;
	localparam int unsigned src_ptm1 = 9;
	localparam int unsigned src_motor_pos = 10;
	localparam int unsigned src_adc = 11;
	localparam int unsigned src_tbt = 12;
	localparam int unsigned src_wpre = 13;
	localparam int unsigned src_cmp0 = 14;
	localparam int unsigned src_cmp1 = 15;
	localparam int unsigned src_ctm1_lo = 16;
	localparam int unsigned src_flash = 17;
endpackage

/* logic/irq_priority_pick.sv */
/*
 Fixed-priority pick among fourteen requests: best level first (0 is
 highest), then the lowest request number. Purely combinational.
 Assumes levels of 3 mean the request is never serviced.
*/
`timescale 1ns/100ps
module irq_priority_pick
	import irq_map_pkg::*;
(
	// Requests and levels
	input wire logic [num_irq-1:0] req,
	input wire logic [2*num_irq-1:0] levels,
	// Winner
	output logic found,
	output logic [3:0] win_idx,
	output logic [1:0] win_lvl
);
	always_comb
	begin
		found = 1'b0;
		win_idx = 4'h0;
		win_lvl = 2'h3;
		// Strictly better wins, so equal levels keep the lower number
		for (int i = 0; i < num_irq; i++)
		begin
			if (req[i] && levels[2*i +: 2] != 2'h3 &&
				(!found || levels[2*i +: 2] < win_lvl))
			begin
				found = 1'b1;
				win_idx = 4'(i);
				win_lvl = levels[2*i +: 2];
			end
		end
	end
endmodule // irq_priority_pick

/* logic/irq_vector_map.sv */
/*
 Interrupt request map for requests 10 to 23 with level registers,
 sticky status, mask, and a vector offer to the CPU core.
 Assumes synchronous, single-cycle-high or level source pulses, and a
 CPU that pulses cpu_ack while the offered vector is valid.
*/
`timescale 1ns/100ps
module irq_vector_map
	import irq_map_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Peripheral sources
	input wire logic [num_src-1:0] src_irq,
	// CPU side
	input wire logic cpu_ack,
	output logic cpu_req,
	output logic [1:0] cpu_level,
	output logic [4:0] cpu_irq_num,
	output logic [15:0] cpu_vec_upper,
	output logic [15:0] cpu_vec_lower,
	output logic cpu_taken,
	// Summary interrupt
	output logic irq,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ---------------------------------------------------------------
	// Source to request mapping
	// ---------------------------------------------------------------
	function automatic logic is_level_off(input logic [7:0] a);
		return a == off_lvl_two || a == off_lvl_three ||
			a == off_lvl_four || a == off_lvl_five;
	endfunction

	wire logic [num_irq-1:0] line;
	assign line[0] = src_irq[src_ppu1_hi];
	assign line[1] = src_irq[src_ppu2_hi];
	assign line[2] = src_irq[src_ppu0_hi];
	assign line[3] = src_irq[src_ppu0_lo];
	assign line[4] = src_irq[src_ctm1_hi];
	assign line[5] = src_irq[src_ppu2_lo];
	assign line[6] = src_irq[src_reload1] | src_irq[src_motor_wt];
	assign line[7] = src_irq[src_i2c0] | src_irq[src_ptm1] |
		src_irq[src_motor_pos];
	assign line[8] = src_irq[src_adc];
	assign line[9] = src_irq[src_tbt] | src_irq[src_wpre];
	assign line[10] = src_irq[src_cmp0];
	assign line[11] = src_irq[src_cmp1];
	assign line[12] = src_irq[src_ctm1_lo];
	assign line[13] = src_irq[src_flash];

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	// Level reg two holds requests 8..11; 8 and 9 live elsewhere
	logic [7:0] lvl_q [4];
	logic [num_irq-1:0] status_q;
	logic [num_irq-1:0] mask_q;
	logic [num_irq-1:0] pend_q;
	wire logic [2*num_irq-1:0] levels;

	genvar g;
	generate
		for (g = 0; g < num_irq; g++)
		begin : g_lvl
			// Request 10+g sits in field (10+g)%4 of reg (10+g)/4-2
			localparam int unsigned n = first_irq + g;
			assign levels[2*g +: 2] =
				lvl_q[n/lvl_per_reg - 2][lvl_field_w*(n%lvl_per_reg) +: 2];
		end
	endgenerate

	// ---------------------------------------------------------------
	// AXI4-Lite write path
	// ---------------------------------------------------------------
	logic aw_held_q;
	logic w_held_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	wire logic aw_fire = s_axi_awvalid & s_axi_awready;
	wire logic w_fire = s_axi_wvalid & s_axi_wready;
	wire logic have_aw = aw_held_q | aw_fire;
	wire logic have_w = w_held_q | w_fire;
	wire logic do_write = have_aw & have_w & ~s_axi_bvalid;
	wire logic [7:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
	wire logic [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
	wire logic [3:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
	wire logic wr_lo = do_write & wr_strb[0];
	wire logic wr_hi = do_write & wr_strb[1];
	wire logic wr_ok = is_level_off(wr_addr) || wr_addr == off_status ||
		wr_addr == off_mask || wr_addr == off_vector ||
		wr_addr == off_pending;
	wire logic [num_irq-1:0] wr_bits = {wr_data[13:8], wr_data[7:0]};
	wire logic [num_irq-1:0] bit_en = {{6{wr_hi}}, {8{wr_lo}}};
	wire logic [num_irq-1:0] stat_clr =
		(wr_addr == off_status) ? (wr_bits & bit_en) : '0;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= resp_okay;
		end
		else
		begin
			aw_held_q <= have_aw & ~do_write;
			w_held_q <= have_w & ~do_write;
			if (aw_fire)
				awaddr_q <= s_axi_awaddr;
			if (w_fire)
			begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			s_axi_awready <= ~(have_aw & ~do_write) & ~s_axi_awready;
			s_axi_wready <= ~(have_w & ~do_write) & ~s_axi_wready;
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? resp_okay : resp_slverr;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Level, mask, status and pending state
	// ---------------------------------------------------------------
	logic [3:0] win_idx;
	logic [1:0] win_lvl;
	logic found;
	logic [3:0] cpu_irq_num_idx;
	wire logic [num_irq-1:0] eligible = pend_q;
	wire logic [num_irq-1:0] ack_clr =
		(cpu_ack & cpu_req) ? (num_irq'(1) << cpu_irq_num_idx) : '0;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int r = 0; r < 4; r++)
				lvl_q[r] <= lvl_reset;
			status_q <= '0;
			mask_q <= '0;
			pend_q <= '0;
		end
		else
		begin
			for (int r = 0; r < 4; r++)
				if (wr_lo && wr_addr == 8'(r*4))
					lvl_q[r] <= wr_data[7:0];
			if (wr_addr == off_mask)
				mask_q <= (mask_q & ~bit_en) | (wr_bits & bit_en);
			// New event beats a same-cycle clear
			status_q <= (status_q & ~stat_clr) | line;
			pend_q <= (pend_q & ~ack_clr) | line;
		end
	end

	irq_priority_pick u_pick (
		.req(eligible),
		.levels(levels),
		.found(found),
		.win_idx(win_idx),
		.win_lvl(win_lvl)
	);

	// ---------------------------------------------------------------
	// CPU vector offer
	// ---------------------------------------------------------------
	wire logic [15:0] win_upper = vec_upper[win_idx];
	wire logic [4:0] win_num = 5'(first_irq) + {1'b0, win_idx};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cpu_req <= 1'b0;
			cpu_level <= 2'h3;
			cpu_irq_num <= 5'h00;
			cpu_irq_num_idx <= 4'h0;
			cpu_vec_upper <= 16'h0000;
			cpu_vec_lower <= 16'h0000;
			cpu_taken <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			cpu_taken <= cpu_ack & cpu_req;
			// Drop the offer one cycle after an acceptance
			cpu_req <= found & ~(cpu_ack & cpu_req);
			if (found)
			begin
				cpu_level <= win_lvl;
				cpu_irq_num <= win_num;
				cpu_irq_num_idx <= win_idx;
				cpu_vec_upper <= win_upper;
				cpu_vec_lower <= win_upper + 16'h0001;
			end
			irq <= |(status_q & mask_q);
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite read path
	// ---------------------------------------------------------------
	wire logic [7:0] ra = s_axi_araddr;
	wire logic [31:0] rd_word =
		(ra == off_lvl_two) ? {24'h0, lvl_q[0]} :
		(ra == off_lvl_three) ? {24'h0, lvl_q[1]} :
		(ra == off_lvl_four) ? {24'h0, lvl_q[2]} :
		(ra == off_lvl_five) ? {24'h0, lvl_q[3]} :
		(ra == off_status) ? {18'h0, status_q} :
		(ra == off_mask) ? {18'h0, mask_q} :
		(ra == off_vector) ? {cpu_vec_lower, cpu_vec_upper} :
		(ra == off_pending) ? {18'h0, pend_q} : 32'h0000_0000;
	wire logic rd_ok = is_level_off(ra) || ra == off_status ||
		ra == off_mask || ra == off_vector || ra == off_pending;
	wire logic ar_fire = s_axi_arvalid & s_axi_arready;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= resp_okay;
		end
		else
		begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (ar_fire)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_ok ? resp_okay : resp_slverr;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule // irq_vector_map

/* tb/irq_map_sva.sv */
/*
 Port checker for irq_vector_map: vector offer and bus answers.
 Assumes one clock domain and a single outstanding bus transfer.
*/
`timescale 1ns/100ps
module irq_map_sva
	import irq_map_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// CPU side
	input wire logic cpu_ack,
	input wire logic cpu_req,
	input wire logic [1:0] cpu_level,
	input wire logic [4:0] cpu_irq_num,
	input wire logic [15:0] cpu_vec_upper,
	input wire logic [15:0] cpu_vec_lower,
	input wire logic cpu_taken,
	// Bus answers
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ------------------------------
	// Properties
	// ------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_take; cpu_ack && cpu_req |=> cpu_taken && !cpu_req; endproperty
	a_take: assert property (p_take) else $error("ack not taken");
	property p_hold;
		cpu_req && !cpu_ack |=> cpu_req && $stable(cpu_irq_num);
	endproperty
	a_hold: assert property (p_hold) else $error("offer dropped");
	property p_pair; cpu_req |-> cpu_vec_lower == cpu_vec_upper + 16'h0001;
	endproperty
	a_pair: assert property (p_pair) else $error("vector pair");
	property p_num; cpu_req |-> cpu_irq_num inside {[5'h0a:5'h17]}; endproperty
	a_num: assert property (p_num) else $error("request number");
	property p_vec;
		cpu_req |-> cpu_vec_upper == 16'hfffa - {10'h000, cpu_irq_num, 1'b0};
	endproperty
	a_vec: assert property (p_vec) else $error("vector address");
	property p_lvl; cpu_req |-> cpu_level != 2'h3; endproperty
	a_lvl: assert property (p_lvl) else $error("disabled served");
	property p_bonce; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_bonce: assert property (p_bonce) else $error("extra bvalid");
	property p_ronce; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_ronce: assert property (p_ronce) else $error("extra rvalid");
endmodule // irq_map_sva

bind irq_vector_map irq_map_sva irq_map_sva_inst (.*);

/* tb/irq_map_cpu.sv */
/*
 CPU core model that accepts offered vectors after a delay.
 Assumes the offer stands until accepted.
*/
`timescale 1ns/100ps
module irq_map_cpu
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Offer and answer
	input wire logic cpu_req,
	input wire logic [1:0] slow,
	output logic cpu_ack
);
	logic [1:0] wait_q;
	// ------------------------------
	// Accept after slow cycles
	// ------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn || cpu_ack)
		begin
			cpu_ack <= 1'b0;
			wait_q <= 2'h0;
		end
		else if (cpu_req && wait_q >= slow)
			cpu_ack <= 1'b1;
		else if (cpu_req)
			wait_q <= wait_q + 2'h1;
	end
endmodule // irq_map_cpu

/* tb/tb.sv */
/*
 Testbench for irq_vector_map: map, priority, levels, status.
 Assumes the CPU model irq_map_cpu and the bound checker.
*/
`timescale 1ns/100ps
module tb
	import irq_map_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [17:0] src_irq = 18'h00000;
	logic [1:0] slow = 2'h0;
	logic cpu_ack, cpu_req, cpu_taken, irq, s_axi_awready, s_axi_wready;
	logic [1:0] cpu_level, s_axi_bresp, s_axi_rresp;
	logic [4:0] cpu_irq_num;
	logic [15:0] cpu_vec_upper, cpu_vec_lower;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_rdata, s_axi_wdata = 32'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [38:0] vq[$];
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	logic [1:0] lv [14];
	int src_num [18] = '{10, 11, 12, 13, 14, 15, 16, 16, 17, 17, 17, 18, 19,
		19, 20, 21, 22, 23};
	int n_mismatch = 0;
	int checks = 0;
	int cyc = 0;
	integer seed = 32'h08ecdccb;

	irq_vector_map irq_vector_map_inst (.*);
	irq_map_cpu irq_map_cpu_inst (.*);

	// ------------------------------
	// Clock, timeout, checks
	// ------------------------------
	initial forever #2 aclk = ~aclk;
	task give_verdict;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task cmp(input logic [38:0] got, input logic [38:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			give_verdict;
		end
		if (cpu_ack === 1'b1 && cpu_req === 1'b1)
			cmp({cpu_level, cpu_irq_num, cpu_vec_upper, cpu_vec_lower},
				vq.pop_front());
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
			cmp({s_axi_rresp, s_axi_rdata}, rq.pop_front());
		if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
			cmp(39'(s_axi_bresp), 39'(bq.pop_front()));
	end
	task wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e = 2'h0);
		bq.push_back(e);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [33:0] exp);
		rq.push_back(exp);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
	endtask
	task set_levels;
		wr(off_lvl_two, {24'h0, lv[1], lv[0], 4'hf});
		for (int j = 0; j < 3; j++)
			wr(off_lvl_three + 8'(4 * j), {24'h0, lv[5 + 4 * j],
				lv[4 + 4 * j], lv[3 + 4 * j], lv[2 + 4 * j]});
	endtask
	// Expected offers ordered by level, then request number
	task fire(input logic [17:0] m);
		logic [13:0] hit;
		hit = 14'h0000;
		for (int s = 0; s < 18; s++)
			if (m[s])
				hit[src_num[s] - 10] = 1'b1;
		for (int l = 0; l < 3; l++)
			for (int i = 0; i < 14; i++)
				if (hit[i] && lv[i] == l)
					vq.push_back({lv[i], 5'(i + 10), 16'hffe6 - 16'(2 * i),
						16'hffe7 - 16'(2 * i)});
		@(posedge aclk);
		src_irq <= m;
		slow <= 2'($random(seed));
		@(posedge aclk);
		src_irq <= 18'h00000;
		while (vq.size() != 0)
			@(posedge aclk);
		repeat (4) @(posedge aclk);
	endtask

	// ------------------------------
	// Main sequence
	// ------------------------------
	initial
	begin
		for (int i = 0; i < 14; i++)
			lv[i] = 2'h0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 4; i++)
			rd(8'(4 * i), {resp_okay, 32'h000000ff});
		rd(8'h20, {resp_slverr, 32'h0});
		$display("test reset done");
		set_levels;
		for (int r = 0; r < 30; r++)
			fire(r < 18 ? 18'h00001 << r : (r == 18 ? 18'h3ffff :
				18'($random(seed))));
		$display("test map done");
		rd(off_status, {resp_okay, 32'h00003fff});
		cmp(39'(irq), 39'h0);
		wr(off_mask, 32'h00002000);
		repeat (3) @(posedge aclk);
		cmp(39'(irq), 39'h1);
		wr(off_status, 32'h00002000);
		repeat (3) @(posedge aclk);
		cmp(39'(irq), 39'h0);
		wr(8'h24, 32'h00003fff, resp_slverr);
		rd(off_status, {resp_okay, 32'h00001fff});
		rd(off_mask, {resp_okay, 32'h00002000});
		$display("test status done");
		for (int i = 0; i < 13; i++)
			lv[i] = 2'h1;
		set_levels;
		fire(18'h3ffff);
		lv[0] = 2'h3;
		set_levels;
		fire(18'h00003);
		$display("test level done");
		give_verdict;
	end
endmodule // tb
